// File: verilog/psl_consts.svh
// Purpose: Constants for the strap loader and indicator block.
// Assumes: Included by every design file that needs offsets or counts.
// Notes: Definitions only.
//
// Overview of operation
// [R1] Capture three address bits from strap pins.
// [R2] Upper two address bits always zero.
// [R3] Board straps address between 1 and 7.
// [R4] Latch four-bit mode; 0100 selects test tree.
// [R5] Mode 0111 powers the whole chip down.
// [R6] 1100 gigabit full only; 1101 gigabit both.
// [R7] 1111 advertise all; 1110 all but gigabit-half.
// [R8] Reference clock strap enables clock output.
// [R9] Style strap: up single, down tri-colour.
// [R10] Single mode: second indicator shows link.
// [R11] Single mode: first indicator blinks on activity.
// [R12] Tri-colour idle levels encode link speed.
// [R13] Tri-colour activity blinks the low indicators.
// [R14] Board adds pulls where MAC drives straps.
// [R15] Gigabit pairs map straight or swapped A-B, C-D.
// [R16] 10/100: pair A transmits, B receives, swappable.
// [R17] MAC supplies transmit clock, nibble and control.
// [R18] Straps sampled at chip reset rising edge.
// [R19] Blink rate comes from a core clock divider.
`ifndef PSL_CONSTS_SVH
`define PSL_CONSTS_SVH

`define PSL_OFS_CTRL        8'h00
`define PSL_OFS_LINK        8'h04
`define PSL_OFS_STATUS      8'h08
`define PSL_OFS_PAIRMAP     8'h0C
`define PSL_OFS_TXMON       8'h10

`define PSL_CTRL_CROSSED    0
`define PSL_LINK_UP         0
`define PSL_LINK_SPD_LO     1
`define PSL_LINK_ACT        3
`define PSL_ST_ADDR_LO      0
`define PSL_ST_MODE_LO      5
`define PSL_ST_REFCLK       9
`define PSL_ST_SINGLE       10
`define PSL_ST_PDOWN        11
`define PSL_ST_TREE         12
`define PSL_ST_RGMII        13
`define PSL_ST_ADV_LO       14
`define PSL_ST_RUN          20
`define PSL_ST_ADDR_ZERO    21

`define PSL_CTRL_RESET      8'h00
`define PSL_LINK_RESET      8'h00
`define PSL_MODE_TREE       4'h4
`define PSL_MODE_PDOWN      4'h7
`define PSL_MODE_GIG_FD     4'hC
`define PSL_MODE_GIG_ALL    4'hD
`define PSL_MODE_NO_GIG_HD  4'hE
`define PSL_MODE_ALL        4'hF
`define PSL_ADV_GIG_FD      6'h20
`define PSL_ADV_GIG_ALL     6'h30
`define PSL_ADV_NO_GIG_HD   6'h2F
`define PSL_ADV_ALL         6'h3F
`define PSL_ADV_NONE        6'h00

`define PSL_CLK_PERIOD_NS   100
`define PSL_BLINK_HALF_NS   100000000

`define PSL_RESP_OKAY       2'h0
`define PSL_RESP_SLVERR     2'h2

`endif

// File: verilog/psl_pkg.sv
// Purpose: Types shared by the strap loader and indicator block.
// Assumes: Nothing beyond the constants header.
// Notes: Speed codes double as link register field values.
package psl_pkg;

  typedef enum logic [1:0] {
    SPD_10   = 2'b00,
    SPD_100  = 2'b01,
    SPD_1000 = 2'b10
  } psl_speed_type;

  typedef enum logic [2:0] {
    ROLE_CH_A   = 3'b000,
    ROLE_CH_B   = 3'b001,
    ROLE_CH_C   = 3'b010,
    ROLE_CH_D   = 3'b011,
    ROLE_TX     = 3'b100,
    ROLE_RX     = 3'b101,
    ROLE_UNUSED = 3'b110
  } psl_role_type;

  typedef enum logic {
    CAP_WAIT = 1'b0,
    CAP_RUN  = 1'b1
  } psl_cap_state_type;

endpackage

// File: verilog/psl_cfg_if.sv
// Purpose: Carries the captured configuration between the block's modules.
// Assumes: One capture module drives it.
// Notes: All fields are registered at the source.
`timescale 1ns/1ps
interface psl_cfg_if;
  logic [4:0] mgmt_addr;
  logic [3:0] mode;
  logic       refclk_en;
  logic       single_style;
  logic       power_down;
  logic       tree_mode;
  logic       rgmii_mode;
  logic [5:0] advert;
  logic       chip_run;

  modport cap (output mgmt_addr, mode, refclk_en, single_style, power_down,
               tree_mode, rgmii_mode, advert, chip_run);
  modport sink (input mgmt_addr, mode, refclk_en, single_style, power_down,
                tree_mode, rgmii_mode, advert, chip_run);
endinterface

// File: verilog/psl_strap_capture.sv
// Purpose: Latches strap levels when the chip reset is released.
// Assumes: Strap inputs and chip reset are synchronous to the clock.
// Notes: Holds the captured values until the next chip reset release.
`timescale 1ns/1ps
`include "psl_consts.svh"
module psl_strap_capture (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       reset_n,
  input  wire logic [2:0] strap_mgmt_addr,
  input  wire logic [3:0] strap_mode,
  input  wire logic       refclk_out_enable_strap,
  input  wire logic       indicator_style_strap,
  psl_cfg_if.cap          cfg
);
  import psl_pkg::*;

  psl_cap_state_type state_reg;
  logic              reset_n_prev_reg;
  logic              release_edge;

  function automatic logic [5:0] advert_of(input logic [3:0] mode);
    if (mode == `PSL_MODE_GIG_FD) begin
      advert_of = `PSL_ADV_GIG_FD;
    end else if (mode == `PSL_MODE_GIG_ALL) begin
      advert_of = `PSL_ADV_GIG_ALL;
    end else if (mode == `PSL_MODE_NO_GIG_HD) begin
      advert_of = `PSL_ADV_NO_GIG_HD;
    end else if (mode == `PSL_MODE_ALL) begin
      advert_of = `PSL_ADV_ALL;
    end else begin
      advert_of = `PSL_ADV_NONE;
    end
  endfunction

  assign release_edge = reset_n && !reset_n_prev_reg; // R18

  always_ff @(posedge clk) begin
    if (rst) begin
      reset_n_prev_reg <= 1'b1;
    end else begin
      reset_n_prev_reg <= reset_n;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= CAP_WAIT;
    end else begin
      case (state_reg)
        CAP_WAIT: begin
          if (release_edge) begin
            state_reg <= CAP_RUN;
          end
        end
        default: begin
          if (!reset_n) begin
            state_reg <= CAP_WAIT;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg.mgmt_addr    <= 5'h00;
      cfg.mode         <= 4'h0;
      cfg.refclk_en    <= 1'b0;
      cfg.single_style <= 1'b0;
      cfg.power_down   <= 1'b0;
      cfg.tree_mode    <= 1'b0;
      cfg.rgmii_mode   <= 1'b0;
      cfg.advert       <= `PSL_ADV_NONE;
    end else if (release_edge) begin
      cfg.mgmt_addr    <= {2'b00, strap_mgmt_addr}; // R1 R2
      cfg.mode         <= strap_mode; // R4
      cfg.tree_mode    <= (strap_mode == `PSL_MODE_TREE); // R4
      cfg.power_down   <= (strap_mode == `PSL_MODE_PDOWN); // R5
      cfg.rgmii_mode   <= (strap_mode[3:2] == 2'b11); // R6 R7
      cfg.advert       <= advert_of(strap_mode); // R6 R7
      cfg.refclk_en    <= refclk_out_enable_strap; // R8
      cfg.single_style <= indicator_style_strap; // R9
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg.chip_run <= 1'b0;
    end else begin
      cfg.chip_run <= (state_reg == CAP_RUN) && reset_n;
    end
  end

endmodule // psl_strap_capture

// File: verilog/psl_indicator.sv
// Purpose: Drives the two indicator levels from link speed and activity.
// Assumes: Link and activity inputs are synchronous to the clock.
// Notes: Both levels are high while the chip is held in reset.
`timescale 1ns/1ps
`include "psl_consts.svh"
module psl_indicator #(
  parameter int CNT_W       = 20,
  parameter int HALF_CYCLES = 1000000
) (
  input  wire logic    clk,
  input  wire logic    rst,
  psl_cfg_if.sink      cfg,
  input  wire logic    link_up,
  input  wire logic [1:0] speed,
  input  wire logic    activity,
  output logic         first_level,
  output logic         second_level
);
  import psl_pkg::*;

  logic [CNT_W-1:0] div_reg;
  logic             blink_reg;
  logic             act_blink;
  logic             first_next;
  logic             second_next;

  always_ff @(posedge clk) begin
    if (rst || !cfg.chip_run) begin
      div_reg   <= '0;
      blink_reg <= 1'b1;
    end else if (div_reg == CNT_W'(HALF_CYCLES - 1)) begin
      div_reg   <= '0;
      blink_reg <= !blink_reg; // R19
    end else begin
      div_reg   <= div_reg + 1'b1; // R19
    end
  end

  assign act_blink = activity ? blink_reg : 1'b0;

  always_comb begin
    first_next  = 1'b1;
    second_next = 1'b1;
    if (cfg.single_style) begin
      second_next = !link_up; // R10
      first_next  = activity ? blink_reg : 1'b1; // R11
    end else if (link_up) begin
      case (speed)
        SPD_1000: begin
          second_next = act_blink; // R12 R13
          first_next  = 1'b1; // R12
        end
        SPD_100: begin
          second_next = 1'b1; // R12
          first_next  = act_blink; // R12 R13
        end
        default: begin
          second_next = act_blink; // R12 R13
          first_next  = act_blink; // R12 R13
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !cfg.chip_run) begin
      first_level  <= 1'b1;
      second_level <= 1'b1;
    end else begin
      first_level  <= first_next;
      second_level <= second_next;
    end
  end

endmodule // psl_indicator

// File: verilog/psl_top.sv
// Purpose: Strap loader, indicator driver and pair role map with a register port.
// Assumes: All inputs are synchronous to SYS_CLK; RST is synchronous, active high.
// Notes: Shared strap pins are read at the first clock edge with RESET_N high; indicator pins are driven after, the clock pin only when enabled.
`timescale 1ns/1ps
`include "psl_consts.svh"
module psl_top #(
  parameter int BLINK_HALF_CYCLES = `PSL_BLINK_HALF_NS / `PSL_CLK_PERIOD_NS,
  parameter int BLINK_CNT_W       = 20
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  input  wire logic        RESET_N,
  input  wire logic        STRAP_ADDR2,
  input  wire logic [3:0]  STRAP_MODE,
  input  wire logic        REFCLK_OUT_ENABLE_STRAP,
  input  wire logic        INDICATOR_FIRST_I,
  output logic             INDICATOR_FIRST_O,
  output logic             INDICATOR_FIRST_OE,
  input  wire logic        INDICATOR_SECOND_I,
  output logic             INDICATOR_SECOND_O,
  output logic             INDICATOR_SECOND_OE,
  input  wire logic        REFCLK_OUT_PIN_I,
  output logic             REFCLK_OUT_PIN_O,
  output logic             REFCLK_OUT_PIN_OE,
  input  wire logic        TX_REF_CLOCK_IN,
  input  wire logic [3:0]  TX_NIBBLE,
  input  wire logic        TX_CONTROL,
  output logic [4:0]       MGMT_ADDR,
  output logic             POWER_DOWN,
  output logic             TEST_TREE_MODE,
  output logic [5:0]       ADVERTISE,
  output psl_pkg::psl_role_type PAIR_ROLE_A,
  output psl_pkg::psl_role_type PAIR_ROLE_B,
  output psl_pkg::psl_role_type PAIR_ROLE_C,
  output psl_pkg::psl_role_type PAIR_ROLE_D,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY
);
  import psl_pkg::*;

  psl_cfg_if cfg ();

  logic [7:0]   ctrl_reg;
  logic [7:0]   link_reg;
  logic [5:0]   txmon_reg;
  logic         aw_hold_reg;
  logic [7:0]   aw_addr_reg;
  logic         w_hold_reg;
  logic [7:0]   w_byte_reg;
  logic         w_lane0_reg;
  logic         refclk_tog_reg;
  psl_role_type role_reg [4];
  psl_role_type role_next [4];
  logic         first_level;
  logic         second_level;
  logic [31:0]  status_word;
  logic [31:0]  pairmap_word;
  logic         link_gig;

  // Register index decode, shared by the write and read paths.
  function automatic logic [2:0] reg_index(input logic [7:0] addr);
    if (addr == `PSL_OFS_CTRL) begin
      reg_index = 3'h1;
    end else if (addr == `PSL_OFS_LINK) begin
      reg_index = 3'h2;
    end else if (addr == `PSL_OFS_STATUS) begin
      reg_index = 3'h3;
    end else if (addr == `PSL_OFS_PAIRMAP) begin
      reg_index = 3'h4;
    end else if (addr == `PSL_OFS_TXMON) begin
      reg_index = 3'h5;
    end else begin
      reg_index = 3'h0;
    end
  endfunction

  // Role of media pair idx for the current speed and crossover setting.
  function automatic psl_role_type pair_role(input int idx, input logic gig,
                                             input logic crossed);
    if (gig) begin
      case (idx)
        0:       pair_role = crossed ? ROLE_CH_B : ROLE_CH_A;
        1:       pair_role = crossed ? ROLE_CH_A : ROLE_CH_B;
        2:       pair_role = crossed ? ROLE_CH_D : ROLE_CH_C;
        default: pair_role = crossed ? ROLE_CH_C : ROLE_CH_D;
      endcase
    end else begin
      case (idx)
        0:       pair_role = crossed ? ROLE_RX : ROLE_TX;
        1:       pair_role = crossed ? ROLE_TX : ROLE_RX;
        default: pair_role = ROLE_UNUSED;
      endcase
    end
  endfunction

  // Address bits 1 and 0 share the indicator pins; the style strap shares
  // the reference clock pin. Those pins are released during chip reset.
  psl_strap_capture u_cap (
    .clk                     (SYS_CLK),
    .rst                     (RST),
    .reset_n                 (RESET_N),
    .strap_mgmt_addr         ({STRAP_ADDR2, INDICATOR_SECOND_I, INDICATOR_FIRST_I}),
    .strap_mode              (STRAP_MODE),
    .refclk_out_enable_strap (REFCLK_OUT_ENABLE_STRAP),
    .indicator_style_strap   (REFCLK_OUT_PIN_I),
    .cfg                     (cfg.cap)
  );

  psl_indicator #(
    .CNT_W       (BLINK_CNT_W),
    .HALF_CYCLES (BLINK_HALF_CYCLES)
  ) u_ind (
    .clk          (SYS_CLK),
    .rst          (RST),
    .cfg          (cfg.sink),
    .link_up      (link_reg[`PSL_LINK_UP]),
    .speed        (link_reg[`PSL_LINK_SPD_LO +: 2]),
    .activity     (link_reg[`PSL_LINK_ACT]),
    .first_level  (first_level),
    .second_level (second_level)
  );

  // Indicator pins drive only once straps are captured.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      INDICATOR_FIRST_O   <= 1'b1;
      INDICATOR_SECOND_O  <= 1'b1;
      INDICATOR_FIRST_OE  <= 1'b0;
      INDICATOR_SECOND_OE <= 1'b0;
    end else begin
      INDICATOR_FIRST_O   <= first_level; // R11 R12
      INDICATOR_SECOND_O  <= second_level; // R10 R12
      INDICATOR_FIRST_OE  <= cfg.chip_run; // R18
      INDICATOR_SECOND_OE <= cfg.chip_run; // R18
    end
  end

  // Reference clock output toggles at half the core rate when enabled.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      refclk_tog_reg    <= 1'b0;
      REFCLK_OUT_PIN_O  <= 1'b0;
      REFCLK_OUT_PIN_OE <= 1'b0;
    end else begin
      refclk_tog_reg    <= !refclk_tog_reg;
      REFCLK_OUT_PIN_O  <= refclk_tog_reg && cfg.refclk_en && !cfg.power_down; // R8 R5
      REFCLK_OUT_PIN_OE <= cfg.chip_run && cfg.refclk_en && !cfg.power_down; // R8 R5
    end
  end

  // Captured configuration outputs.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      MGMT_ADDR      <= 5'h00;
      POWER_DOWN     <= 1'b0;
      TEST_TREE_MODE <= 1'b0;
      ADVERTISE      <= `PSL_ADV_NONE;
    end else begin
      MGMT_ADDR      <= cfg.mgmt_addr; // R1 R2
      POWER_DOWN     <= cfg.power_down; // R5
      TEST_TREE_MODE <= cfg.tree_mode; // R4
      ADVERTISE      <= cfg.advert; // R6 R7
    end
  end

  assign link_gig = (link_reg[`PSL_LINK_SPD_LO +: 2] == SPD_1000);

  generate
    for (genvar p = 0; p < 4; p++) begin : g_pair
      assign role_next[p] = pair_role(p, link_gig, ctrl_reg[`PSL_CTRL_CROSSED]); // R15 R16
      always_ff @(posedge SYS_CLK) begin
        if (RST) begin
          role_reg[p] <= pair_role(p, 1'b0, 1'b0);
        end else begin
          role_reg[p] <= role_next[p];
        end
      end
    end
  endgenerate

  assign PAIR_ROLE_A = role_reg[0];
  assign PAIR_ROLE_B = role_reg[1];
  assign PAIR_ROLE_C = role_reg[2];
  assign PAIR_ROLE_D = role_reg[3];

  // Transmit-side inputs from the MAC, seen only in reduced gigabit mode.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      txmon_reg <= 6'h00;
    end else if (cfg.rgmii_mode) begin
      txmon_reg <= {TX_REF_CLOCK_IN, TX_CONTROL, TX_NIBBLE}; // R17
    end
  end

  assign status_word = {10'h0,
                        (cfg.mgmt_addr[2:0] == 3'h0), // R3
                        cfg.chip_run,
                        cfg.advert,
                        cfg.rgmii_mode,
                        cfg.tree_mode,
                        cfg.power_down,
                        cfg.single_style,
                        cfg.refclk_en,
                        cfg.mode,
                        cfg.mgmt_addr};

  assign pairmap_word = {20'h00000, role_reg[3], role_reg[2], role_reg[1], role_reg[0]};

  // Write channel: address and data are taken in either order.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      aw_hold_reg   <= 1'b0;
      aw_addr_reg   <= 8'h00;
      S_AXI_AWREADY <= 1'b1;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_hold_reg   <= 1'b1;
      aw_addr_reg   <= S_AXI_AWADDR;
      S_AXI_AWREADY <= 1'b0;
    end else if (aw_hold_reg && w_hold_reg && !S_AXI_BVALID) begin
      aw_hold_reg   <= 1'b0;
    end else if (S_AXI_BVALID && S_AXI_BREADY) begin
      S_AXI_AWREADY <= 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      w_hold_reg   <= 1'b0;
      w_byte_reg   <= 8'h00;
      w_lane0_reg  <= 1'b0;
      S_AXI_WREADY <= 1'b1;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_hold_reg   <= 1'b1;
      w_byte_reg   <= S_AXI_WDATA[7:0];
      w_lane0_reg  <= S_AXI_WSTRB[0];
      S_AXI_WREADY <= 1'b0;
    end else if (aw_hold_reg && w_hold_reg && !S_AXI_BVALID) begin
      w_hold_reg   <= 1'b0;
    end else if (S_AXI_BVALID && S_AXI_BREADY) begin
      S_AXI_WREADY <= 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= `PSL_RESP_OKAY;
    end else if (aw_hold_reg && w_hold_reg && !S_AXI_BVALID) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= (reg_index(aw_addr_reg) == 3'h0) ? `PSL_RESP_SLVERR : `PSL_RESP_OKAY;
    end else if (S_AXI_BVALID && S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // Software-written control and link registers.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ctrl_reg <= `PSL_CTRL_RESET;
      link_reg <= `PSL_LINK_RESET;
    end else if (aw_hold_reg && w_hold_reg && !S_AXI_BVALID && w_lane0_reg) begin
      if (reg_index(aw_addr_reg) == 3'h1) begin
        ctrl_reg <= {7'h00, w_byte_reg[`PSL_CTRL_CROSSED]};
      end else if (reg_index(aw_addr_reg) == 3'h2) begin
        link_reg <= {4'h0, w_byte_reg[3:0]};
      end
    end
  end

  // Read channel: one cycle from address to data.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h00000000;
      S_AXI_RRESP   <= `PSL_RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1;
      S_AXI_RRESP   <= `PSL_RESP_OKAY;
      case (reg_index(S_AXI_ARADDR))
        3'h1: S_AXI_RDATA <= {24'h000000, ctrl_reg};
        3'h2: S_AXI_RDATA <= {24'h000000, link_reg};
        3'h3: S_AXI_RDATA <= status_word;
        3'h4: S_AXI_RDATA <= pairmap_word;
        3'h5: S_AXI_RDATA <= {26'h0, txmon_reg};
        default: begin
          S_AXI_RDATA <= 32'h00000000;
          S_AXI_RRESP <= `PSL_RESP_SLVERR;
        end
      endcase
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID  <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

endmodule // psl_top

// File: verification/psl_board_model.sv
// Purpose: Board pulls on the shared strap and indicator pins.
// Assumes: An undriven pin settles to its pull level.
// Notes: Bit 2 is the style pin, bits 1 and 0 the address pins.
`timescale 1ns/1ps
module psl_board_model (
  input  wire logic [2:0] pull,
  input  wire logic [2:0] o,
  input  wire logic [2:0] oe,
  output logic      [2:0] pin
);
  assign pin = (oe & o) | (~oe & pull);
endmodule // psl_board_model

// File: verification/psl_top_props.sv
// Purpose: Checks strap capture and pin drive timing at the top ports.
// Assumes: Outputs follow a capture two edges after RESET_N rises.
// Notes: Bound into every psl_top instance.
`timescale 1ns/1ps
module psl_top_props (
  input wire logic       SYS_CLK,
  input wire logic       RST,
  input wire logic       RESET_N,
  input wire logic       STRAP_ADDR2,
  input wire logic [3:0] STRAP_MODE,
  input wire logic       INDICATOR_FIRST_I,
  input wire logic       INDICATOR_SECOND_I,
  input wire logic       INDICATOR_FIRST_OE,
  input wire logic       INDICATOR_SECOND_OE,
  input wire logic       REFCLK_OUT_PIN_O,
  input wire logic       REFCLK_OUT_PIN_OE,
  input wire logic [4:0] MGMT_ADDR,
  input wire logic       POWER_DOWN,
  input wire logic       TEST_TREE_MODE,
  input wire logic [5:0] ADVERTISE,
  input wire logic       S_AXI_ARVALID,
  input wire logic       S_AXI_ARREADY,
  input wire logic       S_AXI_RVALID
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);
  AST_ADDR: assert property ($rose(RESET_N) |-> ##2 MGMT_ADDR[2:0] ==
    $past({STRAP_ADDR2, INDICATOR_SECOND_I, INDICATOR_FIRST_I}, 2)) else $error("address");
  AST_ADDR_HI: assert property (MGMT_ADDR[4:3] == 2'b00) else $error("address top");
  AST_PDOWN: assert property ($rose(RESET_N) |-> ##2 POWER_DOWN ==
    ($past(STRAP_MODE, 2) == 4'h7)) else $error("power down");
  AST_TREE: assert property ($rose(RESET_N) |-> ##2 TEST_TREE_MODE ==
    ($past(STRAP_MODE, 2) == 4'h4)) else $error("test tree");
  AST_ADV: assert property ($rose(RESET_N) |-> ##2 ADVERTISE ==
    (($past(STRAP_MODE[3:2], 2) == 2'b11) ?
    {1'b1, $past(STRAP_MODE[0], 2), {4{$past(STRAP_MODE[1], 2)}}} : 6'h00))
    else $error("advertise");
  AST_OE_OFF: assert property ((!RESET_N) [*3] |=>
    !INDICATOR_FIRST_OE && !INDICATOR_SECOND_OE) else $error("pins driven in reset");
  AST_REF_TOG: assert property (REFCLK_OUT_PIN_OE && $past(REFCLK_OUT_PIN_OE) &&
    $past(REFCLK_OUT_PIN_OE, 2) |-> REFCLK_OUT_PIN_O != $past(REFCLK_OUT_PIN_O))
    else $error("clock out stuck");
  AST_PD_CLK: assert property (POWER_DOWN && $past(POWER_DOWN) |->
    !REFCLK_OUT_PIN_OE) else $error("clock out in power down");
  AST_RD: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=>
    S_AXI_RVALID && !S_AXI_ARREADY) else $error("read answer");
  COV_CAP: cover property ($rose(RESET_N));
  COV_PD: cover property (POWER_DOWN);
  COV_CLK: cover property (REFCLK_OUT_PIN_OE);
endmodule // psl_top_props
bind psl_top psl_top_props chk_u (.*);

// File: verification/psl_top_tb.sv
// Purpose: Self-checking bench for the strap loader and indicator block.
// Assumes: A short blink half period keeps the run brief.
// Notes: Pins resolve through the board model.
`timescale 1ns/1ps
module psl_top_tb;
  import psl_pkg::*;
  logic SYS_CLK = 1'b0;
  logic RST, RESET_N, STRAP_ADDR2, REFCLK_OUT_ENABLE_STRAP, TX_REF_CLOCK_IN, TX_CONTROL;
  logic [3:0] STRAP_MODE, TX_NIBBLE, S_AXI_WSTRB;
  wire INDICATOR_FIRST_I, INDICATOR_SECOND_I, REFCLK_OUT_PIN_I;
  logic INDICATOR_FIRST_O, INDICATOR_FIRST_OE, INDICATOR_SECOND_O, INDICATOR_SECOND_OE;
  logic REFCLK_OUT_PIN_O, REFCLK_OUT_PIN_OE, POWER_DOWN, TEST_TREE_MODE;
  logic [4:0] MGMT_ADDR;
  logic [5:0] ADVERTISE;
  psl_role_type PAIR_ROLE_A, PAIR_ROLE_B, PAIR_ROLE_C, PAIR_ROLE_D;
  logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, d;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, r;
  logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID;
  logic S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
  logic [2:0] pull;
  int miscompares, n_tests;
  psl_top #(.BLINK_HALF_CYCLES(4)) dut_u (.*);
  psl_board_model brd_u (
    .pull (pull),
    .o    ({REFCLK_OUT_PIN_O, INDICATOR_SECOND_O, INDICATOR_FIRST_O}),
    .oe   ({REFCLK_OUT_PIN_OE, INDICATOR_SECOND_OE, INDICATOR_FIRST_OE}),
    .pin  ({REFCLK_OUT_PIN_I, INDICATOR_SECOND_I, INDICATOR_FIRST_I})
  );
  always #50 SYS_CLK = ~SYS_CLK;
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [39:0] got, input logic [39:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge SYS_CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= v;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    do begin
      @(posedge SYS_CLK);
      if (S_AXI_AWREADY === 1'b1) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY === 1'b1) S_AXI_WVALID <= 1'b0;
    end while (S_AXI_BVALID !== 1'b1);
    rs = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge SYS_CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do begin
      @(posedge SYS_CLK);
      if (S_AXI_ARREADY === 1'b1) S_AXI_ARVALID <= 1'b0;
    end while (S_AXI_RVALID !== 1'b1);
    v = S_AXI_RDATA;
    rs = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
  endtask
  task automatic cap(input logic [3:0] m, input logic [2:0] a, input logic st, input logic rc);
    @(posedge SYS_CLK);
    RESET_N <= 1'b0;
    STRAP_MODE <= m;
    STRAP_ADDR2 <= a[2];
    REFCLK_OUT_ENABLE_STRAP <= rc;
    pull <= {st, a[1:0]};
    repeat (5) @(posedge SYS_CLK);
    RESET_N <= 1'b1;
    repeat (4) @(posedge SYS_CLK);
    {STRAP_MODE, STRAP_ADDR2, REFCLK_OUT_ENABLE_STRAP} <= ~{m, a[2], rc};
  endtask
  task automatic t_modes;
    logic [2:0] a;
    logic [5:0] ad;
    for (int i = 0; i < 16; i++) begin
      a = 3'(i % 7 + 1);
      ad = (i[3] & i[2]) ? {1'b1, i[0], {4{i[1]}}} : 6'h00;
      cap(4'(i), a, i[0], i[1]);
      rd(8'h08, d, r);
      chk("status", d, {10'h0, 2'b01, ad, i[3] & i[2], i == 4, i == 7, i[0], i[1], 4'(i), 2'b00, a});
      chk("cfg", {MGMT_ADDR, POWER_DOWN, TEST_TREE_MODE, ADVERTISE}, {2'b00, a, i == 7, i == 4, ad});
      chk("refclk oe", REFCLK_OUT_PIN_OE, i[1] && i != 7);
    end
  endtask
  task automatic t_misc;
    {TX_REF_CLOCK_IN, TX_CONTROL, TX_NIBBLE} <= 6'h3A;
    repeat (3) @(posedge SYS_CLK);
    rd(8'h10, d, r);
    chk("txmon", {r, d}, 34'h3A);
    rd(8'h40, d, r);
    chk("unmapped read", {r, d}, {2'h2, 32'h0});
    wr(8'h40, 32'h1, r);
    chk("unmapped write", r, 2'h2);
    S_AXI_WSTRB <= 4'h0;
    wr(8'h00, 32'h1, r);
    rd(8'h00, d, r);
    chk("lane gate", {r, d}, 34'h0);
    S_AXI_WSTRB <= 4'h1;
    wr(8'h08, 32'h0, r);
    rd(8'h08, d, r);
    chk("status kept", {r, d}, 34'h001FE7E2);
  endtask
  task automatic t_led(input logic st);
    logic [1:0] idle, tg, lo, hi;
    logic [3:0] lk;
    cap(4'hF, 3'h3, st, 1'b1);
    for (int k = 0; k < 4; k++) begin
      lk = {1'b0, 2'(3 - k), k != 0};
      idle = st ? {k == 0, 1'b1} : {k == 0 || k == 2, k < 2};
      wr(8'h04, {28'h0, lk}, r);
      repeat (4) @(posedge SYS_CLK);
      chk("idle", {INDICATOR_SECOND_O, INDICATOR_FIRST_O}, idle);
      if (k != 0) begin
        tg = st ? 2'b01 : ~idle;
        wr(8'h04, {28'h1, lk[2:0]}, r);
        {lo, hi} = 4'hC;
        repeat (24) begin
          @(posedge SYS_CLK);
          lo &= {INDICATOR_SECOND_O, INDICATOR_FIRST_O};
          hi |= {INDICATOR_SECOND_O, INDICATOR_FIRST_O};
        end
        chk("blink", {hi, lo}, {idle | tg, idle & ~tg});
      end
    end
  endtask
  task automatic t_pairs;
    logic [11:0] e;
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, {31'h0, i[0]}, r);
      wr(8'h04, {29'h0, i[1] ? 2'b10 : 2'b01, 1'b1}, r);
      e = i[1] ? (i[0] ? {ROLE_CH_C, ROLE_CH_D, ROLE_CH_A, ROLE_CH_B} :
          {ROLE_CH_D, ROLE_CH_C, ROLE_CH_B, ROLE_CH_A}) :
          {ROLE_UNUSED, ROLE_UNUSED, i[0] ? ROLE_TX : ROLE_RX, i[0] ? ROLE_RX : ROLE_TX};
      rd(8'h0C, d, r);
      chk("roles", {PAIR_ROLE_D, PAIR_ROLE_C, PAIR_ROLE_B, PAIR_ROLE_A}, e);
      chk("pairmap", d, e);
    end
  endtask
  initial begin
    {RST, RESET_N, STRAP_ADDR2, REFCLK_OUT_ENABLE_STRAP, pull} = 7'h40;
    {TX_REF_CLOCK_IN, TX_CONTROL, TX_NIBBLE, STRAP_MODE, S_AXI_WSTRB} = 14'h1;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = 48'h0;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'h0;
    repeat (20) @(posedge SYS_CLK);
    RST <= 1'b0;
    chk("reset", {ADVERTISE, REFCLK_OUT_PIN_OE, INDICATOR_FIRST_OE}, 8'h00);
    t_modes();
    t_misc();
    t_led(1'b1);
    t_led(1'b0);
    t_pairs();
    close_out();
  end
  initial begin
    repeat (20000) @(posedge SYS_CLK);
    miscompares++;
    close_out();
  end
endmodule // psl_top_tb
